// [design/upconv_pkg.sv]
// Shared types, register map, field positions and filter constants of the upconvert path
package upconv_pkg;

  // ----------------------------------------------------------------
  // Sample carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } iq_s;

  typedef struct packed {
    logic signed [15:0] a;
    logic signed [15:0] b;
  } ab_s;

  // ----------------------------------------------------------------
  // Register indices, one byte each
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_FREQ0    = 4'h0;
  localparam logic [3:0] ADDR_FREQ4    = 4'h4;
  localparam logic [3:0] ADDR_PHASE_LO = 4'h5;
  localparam logic [3:0] ADDR_PHASE_HI = 4'h6;
  localparam logic [3:0] ADDR_TXCONF   = 4'h7;
  localparam logic [3:0] ADDR_OUTCTRL  = 4'h8;
  localparam logic [3:0] ADDR_STATUS   = 4'h9;

  localparam int TX_INTERP_LSB   = 0;
  localparam int TX_MIX_LSB      = 2;
  localparam int TX_LP_BIT       = 5;
  localparam int TX_SINC_BIT     = 6;
  localparam int OUT_BACKOFF_BIT = 0;
  localparam int ST_UNDERRUN_BIT = 0;
  localparam int ST_FIFO_BIT     = 1;

  // 96 MHz at 640 Msps: 0.15 of a turn per sample
  localparam logic [39:0] FREQ_RESET    = 40'h26_6666_6666;
  localparam logic [15:0] PHASE_RESET   = 16'h0000;
  localparam logic [7:0]  TXCONF_RESET  = 8'h00;
  localparam logic [7:0]  OUTCTRL_RESET = 8'h00;

  localparam logic [1:0] INTERP_X2 = 2'h0;
  localparam logic [1:0] INTERP_X4 = 2'h1;
  localparam logic [1:0] INTERP_X8 = 2'h2;

  localparam logic [2:0] MIX_BYPASS  = 3'h0;
  localparam logic [2:0] MIX_USB_POS = 3'h1;
  localparam logic [2:0] MIX_LSB_POS = 3'h2;
  localparam logic [2:0] MIX_USB_NEG = 3'h3;
  localparam logic [2:0] MIX_LSB_NEG = 3'h4;

  localparam logic signed [47:0] BACKOFF_GAIN = 48'sh5A82;
  localparam logic signed [33:0] SIN_CORR     = 34'sh1CCD;
  localparam logic [15:0]        QUARTER_TURN = 16'h4000;
  localparam int                 FIFO_DEPTH   = 4;

  // ----------------------------------------------------------------
  // Filter coefficients, outer tap first up to the centre tap
  // ----------------------------------------------------------------
  localparam int STAGE1_HALF [28] = '{-6, 0, 22, 0, -58, 0, 128, 0, -252, 0, 456, 0,
    -773, 0, 1250, 0, -1951, 0, 2987, 0, -4580, 0, 7302, 0, -13258, 0, 41501, 65536};
  localparam int STAGE2_HALF [12] = '{-21, 0, 159, 0, -654, 0, 1986, 0, -5358, 0,
    20272, 32768};
  localparam int STAGE3_HALF [8]  = '{-3, 0, 27, 0, -127, 0, 615, 1024};
  localparam int SINC_HALF [5]    = '{1, -4, 13, -51, 610};
  localparam int STAGE1_SHIFT = 16;
  localparam int STAGE2_SHIFT = 15;
  localparam int STAGE3_SHIFT = 10;
  // Taps sum to 528 at DC; 124/65536 restores unity
  localparam int SINC_MUL     = 124;
  localparam int SINC_SHIFT   = 16;

  function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sh7FFF) begin
      return 16'sh7FFF;
    end
    if (v < -48'sh8000) begin
      return 16'sh8000;
    end
    return v[15:0];
  endfunction

endpackage

// [design/stream_fifo.sv]
// Small valid/ready FIFO that buffers incoming I/Q words
`timescale 1ns/10ps
module stream_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  // Depth must be a power of two for the pointer wrap
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 count;
  } fifo_s;

  fifo_s st;
  fifo_s next_st;
  logic  push;
  logic  pull;

  assign in_ready  = st.count != (AW+1)'(DEPTH);
  assign out_valid = st.count != '0;
  assign out_data  = st.mem[st.rp];
  assign push      = in_valid && in_ready;
  assign pull      = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp         = st.wp + 1'b1;
    end
    if (pull) begin
      next_st.rp = st.rp + 1'b1;
    end
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pull);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// [design/halfband_fir.sv]
// Symmetric FIR with zero-stuffing load control, rounding and saturation
`timescale 1ns/10ps
module halfband_fir #(
  parameter int N           = 55,
  parameter int HALF        = 28,
  parameter int COEF [HALF] = '{default: 0},
  parameter int SHIFT       = 16,
  parameter int MUL         = 1
) (
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  input  wire logic               en,
  input  wire logic               ld,
  input  wire logic signed [15:0] x,
  output logic signed [15:0]      y
);
  typedef struct packed {
    logic [N-1:0][15:0] tap;
    logic signed [15:0] y;
  } fir_s;

  fir_s st;
  fir_s next_st;

  assign y = st.y;

  // Each enable is one output-rate step; a zero goes in when ld is low
  always_comb begin
    logic signed [47:0] acc;
    logic signed [47:0] nrm;
    acc     = '0;
    nrm     = '0;
    next_st = st;
    if (en) begin
      next_st.tap = {st.tap[N-2:0], ld ? x : 16'h0000};
      for (int n = 0; n < N; n++) begin
        acc = acc + $signed(next_st.tap[n]) * COEF[(n < HALF) ? n : N - 1 - n];
      end
      // Round half up, then clip rather than wrap
      nrm       = (acc * MUL + (48'sh1 <<< (SHIFT - 1))) >>> SHIFT;
      next_st.y = upconv_pkg::sat16(nrm);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// [design/interp_nco_upconvert_path.sv]
// Interpolating I/Q path with oscillator, sideband mixer and sinc compensation
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module interp_nco_upconvert_path (
  input  wire logic            core_clk,
  input  wire logic            arst_n,
  input  wire logic [3:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [7:0]           reg_rdata,
  input  wire logic            in_valid,
  output logic                 in_ready,
  input  wire upconv_pkg::iq_s in_data,
  output upconv_pkg::ab_s      dac_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0][7:0] freq_stage;
    logic [7:0]      phase_stage;
    logic [39:0]     freq_act;
    logic [15:0]     phase_act;
    logic [7:0]      txconf;
    logic [7:0]      outctrl;
    logic [39:0]     acc;
    logic [2:0]      cnt;
    upconv_pkg::ab_s mix;
    upconv_pkg::ab_s dac;
    logic            underrun;
    logic [7:0]      rdata;
  } path_s;

  localparam path_s PATH_RESET = '{
    freq_stage:  upconv_pkg::FREQ_RESET,
    phase_stage: upconv_pkg::PHASE_RESET[7:0],
    freq_act:    upconv_pkg::FREQ_RESET,
    phase_act:   upconv_pkg::PHASE_RESET,
    txconf:      upconv_pkg::TXCONF_RESET,
    outctrl:     upconv_pkg::OUTCTRL_RESET,
    default:     '0
  };

  path_s            st;
  path_s            next_st;
  logic             lp;
  logic             sinc_on;
  logic             backoff;
  logic [1:0]       interp;
  logic [2:0]       mode;
  logic             en1;
  logic             ld1;
  logic             en2;
  logic             ld2;
  logic             ld3;
  logic             pop;
  logic             fifo_valid;
  upconv_pkg::iq_s  fifo_data;
  upconv_pkg::iq_s  f_out;
  logic [1:0][15:0] x1v;
  logic [1:0][15:0] s1v;
  logic [1:0][15:0] s2v;
  logic [1:0][15:0] s3v;
  logic [1:0][15:0] sinc_v;
  logic [15:0]      theta;
  logic signed [15:0] sn;
  logic signed [15:0] cs;

  assign interp    = st.txconf[upconv_pkg::TX_INTERP_LSB +: 2];
  assign mode      = st.txconf[upconv_pkg::TX_MIX_LSB +: 3];
  assign lp        = st.txconf[upconv_pkg::TX_LP_BIT];
  assign sinc_on   = st.txconf[upconv_pkg::TX_SINC_BIT];
  assign backoff   = st.outctrl[upconv_pkg::OUT_BACKOFF_BIT];
  assign reg_rdata = st.rdata;
  assign dac_out   = st.dac;

  // ----------------------------------------------------------------
  // Input buffer
  // ----------------------------------------------------------------
  stream_fifo #(
    .WIDTH (32),
    .DEPTH (upconv_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_data),
    .out_valid (fifo_valid),
    .out_ready (ld1),
    .out_data  (fifo_data)
  );

  assign pop = ld1 && fifo_valid;
  // An empty buffer feeds zeros and flags the underrun
  assign x1v = fifo_valid ? fifo_data : '0;

  // ----------------------------------------------------------------
  // Interpolation schedule
  // ----------------------------------------------------------------
  // Each stage loads on the cycle after its feeder's register updated
  always_comb begin
    en1 = 1'b1;
    ld1 = st.cnt[0] == 1'b0;
    en2 = 1'b1;
    ld2 = st.cnt[0] == 1'b1;
    ld3 = st.cnt[0] == 1'b0;
    case (interp)
      upconv_pkg::INTERP_X2: begin
        en2 = 1'b0;
      end
      upconv_pkg::INTERP_X4: begin
        en1 = st.cnt[0] == 1'b0;
        ld1 = st.cnt[1:0] == 2'h0;
      end
      default: begin
        en1 = st.cnt[1:0] == 2'h0;
        ld1 = st.cnt == 3'h0;
        en2 = st.cnt[0] == 1'b1;
        ld2 = st.cnt[1:0] == 2'h1;
      end
    endcase
  end

  always_comb begin
    case (interp)
      upconv_pkg::INTERP_X2: f_out = s1v;
      upconv_pkg::INTERP_X4: f_out = s2v;
      default:               f_out = s3v;
    endcase
  end

  // ----------------------------------------------------------------
  // Filter stages, one set per channel
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    halfband_fir #(
      .N (55), .HALF (28), .COEF (upconv_pkg::STAGE1_HALF), .SHIFT (upconv_pkg::STAGE1_SHIFT)
    ) u_first_halfband_stage (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .en       (en1),
      .ld       (ld1),
      .x        (x1v[ch]),
      .y        (s1v[ch])
    );
    halfband_fir #(
      .N (23), .HALF (12), .COEF (upconv_pkg::STAGE2_HALF), .SHIFT (upconv_pkg::STAGE2_SHIFT)
    ) u_second_halfband_stage (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .en       (en2),
      .ld       (ld2),
      .x        (s1v[ch]),
      .y        (s2v[ch])
    );
    halfband_fir #(
      .N (15), .HALF (8), .COEF (upconv_pkg::STAGE3_HALF), .SHIFT (upconv_pkg::STAGE3_SHIFT)
    ) u_third_halfband_stage (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .en       (interp != upconv_pkg::INTERP_X2 && interp != upconv_pkg::INTERP_X4),
      .ld       (ld3),
      .x        (s2v[ch]),
      .y        (s3v[ch])
    );
    halfband_fir #(
      .N (9), .HALF (5), .COEF (upconv_pkg::SINC_HALF),
      .SHIFT (upconv_pkg::SINC_SHIFT), .MUL (upconv_pkg::SINC_MUL)
    ) u_inv_sinc (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .en       (1'b1),
      .ld       (1'b1),
      .x        (st.mix[ch*16 +: 16]),
      .y        (sinc_v[ch])
    );
  end

  // ----------------------------------------------------------------
  // Oscillator
  // ----------------------------------------------------------------
  // Parabolic sine with one correction term, error near 0.1 percent
  function automatic logic signed [15:0] osc_sin(input logic [15:0] th);
    logic signed [33:0] x;
    logic signed [33:0] p;
    logic signed [33:0] q;
    logic signed [33:0] r;
    x = {19'h0, th[14:0]};
    p = (x * (34'sh8000 - x)) >>> 13;
    q = (p * p) >>> 15;
    r = p + (((q - p) * upconv_pkg::SIN_CORR) >>> 15);
    if (r > 34'sh7FFF) begin
      r = 34'sh7FFF;
    end
    return th[15] ? 16'(-r) : 16'(r);
  endfunction

  // One phase feeds both paths, so retuning is coherent
  assign theta = lp ? {st.acc[39:35] + st.phase_act[15:11], 11'h000}
                    : st.acc[39:24] + st.phase_act;
  assign sn = osc_sin(theta);
  assign cs = osc_sin(theta + upconv_pkg::QUARTER_TURN);

  function automatic logic signed [15:0] mix_scale(input logic signed [33:0] v,
                                                   input logic bo);
    logic signed [47:0] r;
    r = (48'(v) + 48'sh4000) >>> 15;
    if (bo) begin
      r = (r * upconv_pkg::BACKOFF_GAIN + 48'sh4000) >>> 15;
    end
    return upconv_pkg::sat16(r);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic signed [33:0] ic;
    logic signed [33:0] qs;
    logic signed [33:0] is;
    logic signed [33:0] qc;
    logic signed [33:0] pa;
    logic signed [33:0] pb;
    pa = 34'(f_out.i) <<< 15;
    pb = 34'(f_out.q) <<< 15;
    ic = 34'(f_out.i) * 34'(cs);
    qs = 34'(f_out.q) * 34'(sn);
    is = 34'(f_out.i) * 34'(sn);
    qc = 34'(f_out.q) * 34'(cs);
    next_st       = st;
    next_st.cnt   = st.cnt + 3'h1;
    next_st.rdata = 8'h00;

    if (reg_wr) begin
      if (reg_addr <= upconv_pkg::ADDR_FREQ4) begin
        next_st.freq_stage[reg_addr[2:0]] = reg_wdata;
      end
      case (reg_addr)
        upconv_pkg::ADDR_FREQ4:    next_st.freq_act = {reg_wdata, st.freq_stage[3:0]};
        upconv_pkg::ADDR_PHASE_LO: next_st.phase_stage = reg_wdata;
        upconv_pkg::ADDR_PHASE_HI: next_st.phase_act = {reg_wdata, st.phase_stage};
        upconv_pkg::ADDR_TXCONF:   next_st.txconf = reg_wdata;
        upconv_pkg::ADDR_OUTCTRL:  next_st.outctrl = reg_wdata;
        default: begin
        end
      endcase
    end

    if (reg_rd) begin
      if (reg_addr <= upconv_pkg::ADDR_FREQ4) begin
        next_st.rdata = st.freq_stage[reg_addr[2:0]];
      end
      case (reg_addr)
        upconv_pkg::ADDR_PHASE_LO: next_st.rdata = st.phase_stage;
        upconv_pkg::ADDR_PHASE_HI: next_st.rdata = st.phase_act[15:8];
        upconv_pkg::ADDR_TXCONF:   next_st.rdata = st.txconf;
        upconv_pkg::ADDR_OUTCTRL:  next_st.rdata = st.outctrl;
        upconv_pkg::ADDR_STATUS: begin
          next_st.rdata[upconv_pkg::ST_UNDERRUN_BIT] = st.underrun;
          next_st.rdata[upconv_pkg::ST_FIFO_BIT]     = fifo_valid;
          next_st.underrun                           = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // A new underrun beats the clear-on-read
    if (ld1 && !fifo_valid) begin
      next_st.underrun = 1'b1;
    end

    if (lp) begin
      next_st.acc = {st.acc[39:35] + st.freq_act[39:35], 35'h0};
    end else begin
      next_st.acc = st.acc + st.freq_act;
    end

    case (mode)
      upconv_pkg::MIX_USB_POS: begin
        pa = ic - qs;
        pb = is + qc;
      end
      upconv_pkg::MIX_LSB_POS: begin
        pa = ic + qs;
        pb = is - qc;
      end
      upconv_pkg::MIX_USB_NEG: begin
        pa = ic - qs;
        pb = -is - qc;
      end
      upconv_pkg::MIX_LSB_NEG: begin
        pa = ic + qs;
        pb = -is + qc;
      end
      default: begin
        // Undefined codes keep the bypass values set above
      end
    endcase
    next_st.mix.a = mix_scale(pa, backoff);
    next_st.mix.b = mix_scale(pb, backoff);
    next_st.dac   = sinc_on ? sinc_v : st.mix;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= PATH_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_freq_apply: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_wr && reg_addr == upconv_pkg::ADDR_FREQ4 |=>
      st.freq_act[39:32] == $past(reg_wdata) && st.freq_act[7:0] == $past(st.freq_stage[0]))
    else $error("frequency word not applied after top byte write");

  a_acc_full_step: assert property (@(posedge core_clk) disable iff (!arst_n)
    arst_n && !lp |=> st.acc == $past(st.acc) + $past(st.freq_act))
    else $error("phase accumulator full step wrong");

  a_phase_apply: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_wr && reg_addr == upconv_pkg::ADDR_PHASE_HI |=>
      st.phase_act == {$past(reg_wdata), $past(st.phase_stage)})
    else $error("phase offset not applied after high byte write");

  a_acc_lp_step: assert property (@(posedge core_clk) disable iff (!arst_n)
    lp |=> st.acc[39:35] == $past(st.acc[39:35]) + $past(st.freq_act[39:35]))
    else $error("low power accumulator step wrong");

  a_lp_phase_bits: assert property (@(posedge core_clk) disable iff (!arst_n)
    lp |-> theta[10:0] == 11'h000 && theta[15:11] == st.acc[39:35] + st.phase_act[15:11])
    else $error("low power phase uses wrong bits");

  a_bypass_path: assert property (@(posedge core_clk) disable iff (!arst_n)
    mode == upconv_pkg::MIX_BYPASS && !backoff |=>
      st.mix.a == $past(f_out.i) && st.mix.b == $past(f_out.q))
    else $error("bypass does not pass I and Q");

  a_backoff_gain: assert property (@(posedge core_clk) disable iff (!arst_n)
    mode == upconv_pkg::MIX_BYPASS && backoff && f_out.i == 16'sh7FFF |=>
      st.mix.a == 16'sh5A81)
    else $error("backoff gain wrong at full scale");

  a_x8_pop_rate: assert property (@(posedge core_clk) disable iff (!arst_n)
    pop && interp == upconv_pkg::INTERP_X8 |=> (!pop) [*7])
    else $error("x8 mode takes input faster than one in eight");

endmodule

// [dv/iq_source.sv]
// Partner model: upstream I/Q sample source feeding the input FIFO
`timescale 1ns/10ps
module iq_source (
  input  wire logic            core_clk,
  input  wire logic            arst_n,
  input  wire logic            run,
  input  wire upconv_pkg::iq_s level,
  input  wire logic            in_ready,
  output logic                 in_valid,
  output upconv_pkg::iq_s      in_data
);
  // Word held until taken; stale word inverted so an idle bus never looks fresh
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_valid <= 1'b0;
      in_data  <= '0;
    end else if (!in_valid || in_ready) begin
      in_valid <= run;
      in_data  <= run ? level : ~in_data;
    end
  end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the interpolating upconvert path
`timescale 1ns/10ps
module testbench;
  logic            core_clk  = 1'b0;
  logic            arst_n    = 1'b0;
  logic [3:0]      reg_addr  = 4'h0;
  logic [7:0]      reg_wdata = 8'h00;
  logic            reg_wr    = 1'b0;
  logic            reg_rd    = 1'b0;
  logic            run       = 1'b0;
  logic            look      = 1'b0;
  logic            rd_d      = 1'b0;
  logic [7:0]      reg_rdata;
  logic            in_valid;
  logic            in_ready;
  upconv_pkg::iq_s in_data;
  upconv_pkg::iq_s level     = '0;
  upconv_pkg::ab_s dac_out;
  int              num_errors   = 0;
  int              total_checks = 0;
  logic [7:0]      rd_q [$];
  logic [32:0]     out_q [$];

  always #5 core_clk = ~core_clk;

  interp_nco_upconvert_path i_dut (.core_clk(core_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .dac_out(dac_out));
  iq_source i_src (.core_clk(core_clk), .arst_n(arst_n), .run(run), .level(level),
    .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data));

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic bad(input logic [31:0] e, input logic [31:0] g);
    num_errors++;
    $display("wrong value at %0t: expected %h got %h", $time, e, g);
  endtask

  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad(32'(e), 32'(g));
    end
  endtask

  task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad(e, g);
    end
  endtask

  // Oscillator is approximate, so only the power of A and B is judged, within 2 %
  task automatic cmp_mag(input logic [31:0] e, input upconv_pkg::ab_s g);
    longint p;
    p = longint'(g.a) * g.a + longint'(g.b) * g.b;
    total_checks++;
    if ((^g === 1'bx) || (p > e + e / 50) || (p < e - e / 50)) begin
      bad(e, p[31:0]);
    end
  endtask

  task automatic end_sim;
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      cmp_byte(rd_q.pop_front(), reg_rdata);
    end
    if (look) begin
      if (out_q[0][32]) begin
        cmp_mag(out_q[0][31:0], dac_out);
      end else begin
        cmp_word(out_q[0][31:0], dac_out);
      end
      void'(out_q.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask

  // Stream stopped first: the pop spacing must not change mid-stream
  task automatic cfg(input logic [7:0] t, input upconv_pkg::iq_s v);
    run <= 1'b0;
    repeat (40) @(posedge core_clk);
    wr(upconv_pkg::ADDR_TXCONF, t);
    level <= v;
    run   <= 1'b1;
    rd(upconv_pkg::ADDR_TXCONF, t);
  endtask

  // Long settle covers the x8 filter chain fill
  task automatic expect_out(input logic mag, input logic [31:0] e);
    repeat (500) @(posedge core_clk);
    out_q.push_back({mag, e});
    look <= 1'b1;
    @(posedge core_clk);
    look <= 1'b0;
  endtask

  function automatic logic [15:0] dc(input logic signed [15:0] v, input bit s);
    longint g;
    g = 528 * upconv_pkg::SINC_MUL;
    return s ? 16'((longint'(v) * g + 32768) >>> upconv_pkg::SINC_SHIFT) : v;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0]         modes [5];
    logic signed [15:0] x;
    modes = '{8'h00, 8'h01, 8'h02, 8'h1F, 8'h40};
    void'($urandom(58));
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 5; i++) begin
      rd(4'(i), upconv_pkg::FREQ_RESET[8*i+:8]);
    end
    rd(upconv_pkg::ADDR_PHASE_HI, 8'h00);
    rd(upconv_pkg::ADDR_OUTCTRL, upconv_pkg::OUTCTRL_RESET);
    rd(4'hF, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(4'(i), 8'h00);
    end
    rd(upconv_pkg::ADDR_FREQ4, 8'h00);
    wr(upconv_pkg::ADDR_PHASE_LO, 8'h00);
    wr(upconv_pkg::ADDR_PHASE_HI, 8'h40);
    for (int m = 0; m < 5; m++) begin
      x = 16'(int'($urandom_range(16000)) - 8000);
      cfg(modes[m], {x, -x});
      expect_out(1'b0, {dc(x, m == 4), dc(-x, m == 4)});
    end
    for (int k = 0; k < 8; k++) begin
      x = 16'($urandom_range(11000, 2000));
      wr(upconv_pkg::ADDR_OUTCTRL, 8'(k / 4));
      cfg({2'b00, 1'(k % 2), 3'(1 + k % 4), 2'b00}, {x, x});
      expect_out(1'b1, 32'(longint'(x) * x * 2 / (1 + k / 4)));
    end
    // Backoff still on from the last pass: full-scale bypass through it
    cfg(8'h00, {16'h7FFF, 16'h8000});
    expect_out(1'b0, {16'h5A81, 16'hA57E});
    cfg(8'h02, 32'h0100_0100);
    rd(upconv_pkg::ADDR_STATUS, 8'h03);
    rd(upconv_pkg::ADDR_STATUS, 8'h02);
    for (int n = 0; in_ready !== 1'b0; n++) begin
      if (n == 40) begin
        bad(32'h0, 32'h1);
        end_sim();
      end
      @(negedge core_clk);
    end
    total_checks++;
    run <= 1'b0;
    repeat (60) @(posedge core_clk);
    rd(upconv_pkg::ADDR_STATUS, 8'h01);
    repeat (3) @(posedge core_clk);
    end_sim();
  end
endmodule
